//--- sprc_pkg.sv
// constants and types for the sleep, power and reset controller
package sprc_pkg;
	localparam logic [3:0] ADDR_CTRL    = 4'h0;
	localparam logic [3:0] ADDR_PRR     = 4'h4;
	localparam logic [3:0] ADDR_STATUS  = 4'h8;
	localparam logic [3:0] ADDR_SLPCMD  = 4'hC;
	localparam int         BIT_BROWNOUT_SLEEP_OFF     = 7;
	localparam int         BIT_SE       = 5;
	localparam int         BIT_SM_HI    = 4;
	localparam int         BIT_SM_LO    = 3;
	localparam int         BIT_BROWNOUT_SLEEP_UNLOCK    = 2;
	localparam int         BIT_TIM1     = 3;
	localparam int         BIT_TIM0     = 2;
	localparam int         BIT_USI      = 1;
	localparam int         BIT_ADC      = 0;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] PRR_RESET    = 8'h00;
	localparam logic [7:0] CTRL_WMASK   = 8'h7F;
	localparam logic [7:0] PRR_WMASK    = 8'h0F;
	localparam logic [2:0] UNLOCK_WIN   = 3'h4;
	localparam logic [1:0] BROWNOUT_SLEEP_OFF_DELAY   = 2'h3;
	localparam logic [1:0] BROWNOUT_SLEEP_OFF_LIFE    = 2'h3;
	localparam logic [2:0] STANDBY_WAKE = 3'h6;
	localparam int         TOUT_W       = 16;
	typedef enum logic [1:0] {
		SPRC_IDLE,
		SPRC_NOISE,
		SPRC_PDOWN,
		SPRC_STANDBY
	} sprc_mode_type;
	typedef enum {
		SPRC_RUN,
		SPRC_SLEEP,
		SPRC_WAKE
	} sprc_state_type;
endpackage

//--- sprc_if.sv
// reset stretcher carrier between controller and its delay counter
`timescale 1ns/10ps
interface sprc_rst_if;
	logic                             src_active;
	logic [sprc_pkg::TOUT_W-1:0]      tout_cycles;
	logic                             hold;
	modport ctrl (output src_active, output tout_cycles, input hold);
	modport cnt  (input src_active, input tout_cycles, output hold);
endinterface

//--- sprc_delay.sv
// reset delay counter that stretches internal reset
`timescale 1ns/10ps
module sprc_delay (
	input  wire logic pclk,
	sprc_rst_if.cnt   rif
);
	logic [sprc_pkg::TOUT_W-1:0] count_ff;
	logic                        hold_ff;
	wire                         done = (count_ff == '0);
	// any active source clears at once, with no clock
	always_ff @(posedge pclk or posedge rif.src_active) begin
		if (rif.src_active) begin
			count_ff <= '0;
			hold_ff  <= 1'b1;
		end else if (hold_ff && count_ff == '0 && rif.tout_cycles != '0) begin
			count_ff <= rif.tout_cycles;
		end else if (!done) begin
			count_ff <= count_ff - 1'b1;
			hold_ff  <= (count_ff != 1'b1) ? 1'b1 : 1'b0;
		end else begin
			hold_ff  <= 1'b0;
		end
	end
	assign rif.hold = hold_ff;
endmodule // sprc_delay

//--- sprc_top.sv
// sleep, power-reduction and reset sequencing controller
// Behaviour
// - unlock write then set write within four cycles
// - brown-out-sleep active three cycles after setting
// - brown-out-sleep self clears three cycles later
// - sleep instruction needs sleep enable set
// - mode field selects idle noise power-down standby
// - bit three freezes timer one
// - bit two freezes timer zero
// - bit one stops serial interface clock
// - comparator loses converter mux while shut
// - reduction bits seven to four read zero
// - deep sleep disables input buffers except wake
// - any reset restores registers and sleep state
// - ports reset asynchronously on any source
// - delay counter stretches reset after sources
// - four reset sources; pin, watchdog and brown-out gated by enables, power-on not
// - power-on reasserts immediately, rise starts delay
// - external pin low resets without clock
// - idle noise power-down stop clock groups
// - standby keeps oscillator, wakes in six cycles
// - watchdog pulse one cycle, delay after it
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
module sprc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [3:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        power_ok,
	input  wire logic        ext_reset_n,
	input  wire logic        ext_reset_enable,
	input  wire logic        watchdog_expire,
	input  wire logic        watchdog_enable,
	input  wire logic        brownout_low,
	input  wire logic        brownout_enable,
	input  wire logic [15:0] tout_cycles,
	input  wire logic        ext_crystal_sel,
	input  wire logic        sleep_instr,
	input  wire logic        wake_event,
	input  wire logic [11:0] wake_pin_mask,
	output logic             internal_reset,
	output logic             io_port_reset,
	output logic             cpu_clock_run,
	output logic             flash_clock_run,
	output logic             io_clock_run,
	output logic             converter_clock_run,
	output logic             osc_run,
	output logic             brownout_detector_off,
	output logic [11:0]      input_buffer_en,
	output logic             timer1_clock_en,
	output logic             timer0_clock_en,
	output logic             serial_iface_clock_en,
	output logic             converter_clock_en,
	output logic             comparator_mux_allow,
	output logic             timer1_access_en,
	output logic             timer0_access_en,
	output logic             serial_iface_access_en,
	output logic             converter_access_en,
	output logic             sleeping
);
	sprc_rst_if rif ();
	logic [7:0]                    ctrl_ff;
	logic [7:0]                    nxt_ctrl;
	logic [7:0]                    prr_ff;
	logic [2:0]                    unlock_ff;
	logic [1:0]                    brownout_sleep_off_age_ff;
	logic                          brownout_sleep_off_act_ff;
	logic                          bod_off_ff;
	logic [2:0]                    wake_cnt_ff;
	logic [31:0]                   prdata_ff;
	logic                          wd_ff;
	sprc_pkg::sprc_state_type      state_ff;
	sprc_pkg::sprc_mode_type       mode_ff;
	wire                           acc       = psel && penable;
	wire                           wr        = acc && pwrite;
	wire                           rd        = acc && !pwrite;
	wire                           hit_ctrl  = (paddr == sprc_pkg::ADDR_CTRL);
	wire                           hit_prr   = (paddr == sprc_pkg::ADDR_PRR);
	wire                           hit_stat  = (paddr == sprc_pkg::ADDR_STATUS);
	wire                           hit_cmd   = (paddr == sprc_pkg::ADDR_SLPCMD);
	wire                           mapped    = hit_ctrl | hit_prr | hit_stat | hit_cmd;
	wire                           wr_ctrl   = wr && hit_ctrl;
	wire                           wr_prr    = wr && hit_prr;
	wire                           w_brownout_sleep_off    = pwdata[sprc_pkg::BIT_BROWNOUT_SLEEP_OFF];
	wire                           w_brownout_sleep_unlock   = pwdata[sprc_pkg::BIT_BROWNOUT_SLEEP_UNLOCK];
	wire                           unlock_wr = wr_ctrl && w_brownout_sleep_off && w_brownout_sleep_unlock;
	wire                           unlocked  = (unlock_ff != '0);
	wire                           brownout_sleep_off_set  = wr_ctrl && w_brownout_sleep_off && !w_brownout_sleep_unlock && unlocked;
	wire                           sleep_go;
	wire                           pin_rst;
	wire                           wd_pulse;
	wire                           any_src;
	wire                           in_sleep  = (state_ff != sprc_pkg::SPRC_RUN);
	wire                           deep;

	// brownout_sleep_off bit set only by the timed sequence
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			nxt_ctrl = (pwdata[7:0] & sprc_pkg::CTRL_WMASK);
			nxt_ctrl[sprc_pkg::BIT_BROWNOUT_SLEEP_OFF] = ctrl_ff[sprc_pkg::BIT_BROWNOUT_SLEEP_OFF];
		end
		if (brownout_sleep_off_set) begin
			nxt_ctrl[sprc_pkg::BIT_BROWNOUT_SLEEP_OFF] = 1'b1;
		end else if (brownout_sleep_off_act_ff && brownout_sleep_off_age_ff == sprc_pkg::BROWNOUT_SLEEP_OFF_LIFE - 2'h1) begin
			nxt_ctrl[sprc_pkg::BIT_BROWNOUT_SLEEP_OFF] = 1'b0;
		end
	end

	// registers fall to reset values under internal reset as well
	always_ff @(posedge pclk or negedge presetn or posedge internal_reset) begin
		if (!presetn || internal_reset) begin
			ctrl_ff <= sprc_pkg::CTRL_RESET;
			prr_ff  <= sprc_pkg::PRR_RESET;
		end else begin
			ctrl_ff <= nxt_ctrl;
			if (wr_prr) begin
				prr_ff <= pwdata[7:0] & sprc_pkg::PRR_WMASK;
			end
		end
	end

	// unlock window counts down four cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock_ff <= '0;
		end else if (unlock_wr) begin
			unlock_ff <= sprc_pkg::UNLOCK_WIN;
		end else if (unlocked) begin
			unlock_ff <= unlock_ff - 3'h1;
		end
	end

	// age counter: active after three cycles, cleared three later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brownout_sleep_off_age_ff <= '0;
			brownout_sleep_off_act_ff <= 1'b0;
		end else if (brownout_sleep_off_set) begin
			brownout_sleep_off_age_ff <= '0;
			brownout_sleep_off_act_ff <= 1'b0;
		end else if (ctrl_ff[sprc_pkg::BIT_BROWNOUT_SLEEP_OFF] && !brownout_sleep_off_act_ff) begin
			brownout_sleep_off_age_ff <= brownout_sleep_off_age_ff + 2'h1;
			brownout_sleep_off_act_ff <= (brownout_sleep_off_age_ff == sprc_pkg::BROWNOUT_SLEEP_OFF_DELAY - 2'h1);
			if (brownout_sleep_off_age_ff == sprc_pkg::BROWNOUT_SLEEP_OFF_DELAY - 2'h1) begin
				brownout_sleep_off_age_ff <= '0;
			end
		end else if (brownout_sleep_off_act_ff) begin
			brownout_sleep_off_age_ff <= brownout_sleep_off_age_ff + 2'h1;
			if (!ctrl_ff[sprc_pkg::BIT_BROWNOUT_SLEEP_OFF]) begin
				brownout_sleep_off_act_ff <= 1'b0;
				brownout_sleep_off_age_ff <= '0;
			end
		end
	end

	// sleep is sleep_instr or an apb command write, since no core is present here
	assign sleep_go = (sleep_instr || (wr && hit_cmd)) && ctrl_ff[sprc_pkg::BIT_SE];

	always_ff @(posedge pclk or negedge presetn or posedge internal_reset) begin
		if (!presetn || internal_reset) begin
			state_ff    <= sprc_pkg::SPRC_RUN;
			mode_ff     <= sprc_pkg::SPRC_IDLE;
			bod_off_ff  <= 1'b0;
			wake_cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				sprc_pkg::SPRC_RUN: begin
					if (sleep_go) begin
						state_ff <= sprc_pkg::SPRC_SLEEP;
						mode_ff  <= sprc_pkg::sprc_mode_type'(
							ctrl_ff[sprc_pkg::BIT_SM_HI:sprc_pkg::BIT_SM_LO]);
						// bod is only dropped in the two deepest modes
						bod_off_ff <= brownout_sleep_off_act_ff && ctrl_ff[sprc_pkg::BIT_SM_HI];
					end
				end
				sprc_pkg::SPRC_SLEEP: begin
					if (wake_event) begin
						bod_off_ff  <= 1'b0;
						state_ff    <= (mode_ff == sprc_pkg::SPRC_STANDBY) ?
							sprc_pkg::SPRC_WAKE : sprc_pkg::SPRC_RUN;
						wake_cnt_ff <= sprc_pkg::STANDBY_WAKE - 3'h1;
					end
				end
				sprc_pkg::SPRC_WAKE: begin
					wake_cnt_ff <= wake_cnt_ff - 3'h1;
					if (wake_cnt_ff == 3'h1) begin
						state_ff <= sprc_pkg::SPRC_RUN;
					end
				end
			endcase
		end
	end

	// clock gating per mode
	wire stop_cpu = in_sleep;
	wire stop_io  = in_sleep && mode_ff != sprc_pkg::SPRC_IDLE;
	wire stop_adc = in_sleep && mode_ff[1];
	assign deep = stop_io && stop_adc;
	assign cpu_clock_run       = !stop_cpu;
	assign flash_clock_run     = !stop_cpu;
	assign io_clock_run        = !stop_io;
	assign converter_clock_run = !stop_adc;
	assign osc_run = !(in_sleep && mode_ff == sprc_pkg::SPRC_PDOWN);
	assign brownout_detector_off = bod_off_ff;
	assign sleeping = in_sleep;
	assign input_buffer_en = deep ? wake_pin_mask : 12'hFFF;

	// peripheral shutdown: clock stopped keeps state frozen
	assign timer1_clock_en       = !prr_ff[sprc_pkg::BIT_TIM1] && !stop_io;
	assign timer0_clock_en       = !prr_ff[sprc_pkg::BIT_TIM0] && !stop_io;
	assign serial_iface_clock_en = !prr_ff[sprc_pkg::BIT_USI] && !stop_io;
	assign converter_clock_en    = !prr_ff[sprc_pkg::BIT_ADC] && !stop_adc;
	assign comparator_mux_allow  = !prr_ff[sprc_pkg::BIT_ADC];
	assign timer1_access_en       = !prr_ff[sprc_pkg::BIT_TIM1];
	assign timer0_access_en       = !prr_ff[sprc_pkg::BIT_TIM0];
	assign serial_iface_access_en = !prr_ff[sprc_pkg::BIT_USI];
	assign converter_access_en    = !prr_ff[sprc_pkg::BIT_ADC];

	// watchdog expiry cut to a single cycle pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_ff <= 1'b0;
		end else begin
			wd_ff <= watchdog_expire;
		end
	end
	assign wd_pulse = watchdog_expire && !wd_ff && watchdog_enable;

	// power-on and pin sources are asynchronous; no sync so they act clockless
	assign pin_rst = ext_reset_enable && !ext_reset_n;
	assign any_src = !power_ok || pin_rst || wd_pulse || (brownout_enable && brownout_low)
		|| !presetn;
	assign rif.src_active  = any_src;
	assign rif.tout_cycles = tout_cycles;

	sprc_delay u_delay (
		.pclk (pclk),
		.rif  (rif)
	);

	assign internal_reset = rif.hold || any_src;
	assign io_port_reset  = any_src || rif.hold;

	// apb read data, registered; zero wait states
	wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_ff} :
		hit_prr  ? {24'h000000, prr_ff} :
		hit_stat ? {28'h0000000, brownout_sleep_off_act_ff, bod_off_ff, mode_ff} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata_ff <= rd_mux;
		end
	end
	assign prdata  = rd ? prdata_ff : 32'h00000000;
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
endmodule // sprc_top

//--- sprc_monitor.sv
// port assertions for the sleep power reset controller
`timescale 1ns/10ps
module sprc_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [3:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        power_ok,
	input wire logic        brownout_low,
	input wire logic        brownout_enable,
	input wire logic        wake_event,
	input wire logic [11:0] wake_pin_mask,
	input wire logic        internal_reset,
	input wire logic        io_port_reset,
	input wire logic        cpu_clock_run,
	input wire logic        io_clock_run,
	input wire logic        converter_clock_run,
	input wire logic        osc_run,
	input wire logic [11:0] input_buffer_en,
	input wire logic        timer0_clock_en,
	input wire logic        timer0_access_en,
	input wire logic        converter_clock_en,
	input wire logic        comparator_mux_allow,
	input wire logic        sleeping
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence deep_s;
		sleeping && !io_clock_run && !converter_clock_run;
	endsequence
	sequence stby_wake_s;
		sleeping && osc_run && !io_clock_run && wake_event;
	endsequence
	// sleep also stops these clocks, so the ties only hold while the clock group runs
	frozen_tie_a: assert property (io_clock_run |-> timer0_clock_en == timer0_access_en)
		else $error("timer0 access differs from its clock gate");
	mux_block_a: assert property (converter_clock_run |-> comparator_mux_allow == converter_clock_en)
		else $error("comparator mux allowed while converter is off");
	por_now_a: assert property (!power_ok |-> internal_reset)
		else $error("supply low without reset");
	bod_src_a: assert property (brownout_enable && brownout_low |-> io_port_reset)
		else $error("enabled brown-out without port reset");
	ports_tie_a: assert property (io_port_reset == internal_reset)
		else $error("port reset differs from internal reset");
	entry_halt_a: assert property ($rose(sleeping) |-> !cpu_clock_run)
		else $error("cpu clock runs on sleep entry");
	deep_buf_a: assert property (deep_s |-> input_buffer_en == wake_pin_mask)
		else $error("input buffers wrong in deep sleep");
	// standby keeps the oscillator, so wake must be quick
	stby_wake_a: assert property (stby_wake_s |-> ##[1:7] !sleeping)
		else $error("standby wake too slow");
	rsvd_zero_a: assert property (psel && penable && !pwrite && paddr == sprc_pkg::ADDR_PRR
		|-> prdata[31:4] == 28'h0)
		else $error("reserved bits read nonzero");
endmodule // sprc_monitor
bind sprc_top sprc_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.power_ok, .brownout_low, .brownout_enable, .wake_event, .wake_pin_mask, .internal_reset,
	.io_port_reset, .cpu_clock_run, .io_clock_run, .converter_clock_run, .osc_run,
	.input_buffer_en, .timer0_clock_en, .timer0_access_en, .converter_clock_en,
	.comparator_mux_allow, .sleeping);

//--- sleep_power_reset_control_tb_top.sv
// self-checking bench for the sleep power reset controller
`timescale 1ns/10ps
module sleep_power_reset_control_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [3:0]  paddr = 4'h0;
	logic [31:0] pwdata = 32'h0;
	logic        power_ok = 1'b1;
	logic        ext_reset_n = 1'b1;
	logic        ext_reset_enable = 1'b1;
	logic        watchdog_expire = 1'b0;
	logic        watchdog_enable = 1'b1;
	logic        brownout_low = 1'b0;
	logic        brownout_enable = 1'b1;
	logic        sleep_instr = 1'b0;
	logic        wake_event = 1'b0;
	logic [15:0] tout_cycles = 16'h0004;
	logic [11:0] wake_pin_mask = 12'hA5A;
	logic [3:0]  mode_exp [4] = '{4'hF, 4'hB, 4'h8, 4'h9};
	logic [31:0] prdata, q;
	logic [11:0] input_buffer_en;
	logic        pready, pslverr, e, internal_reset, io_port_reset, cpu_clock_run;
	logic        flash_clock_run, io_clock_run, converter_clock_run, osc_run, sleeping;
	logic        brownout_detector_off, timer1_clock_en, timer0_clock_en, serial_iface_clock_en;
	logic        converter_clock_en, comparator_mux_allow, timer1_access_en, timer0_access_en;
	logic        serial_iface_access_en, converter_access_en;
	int          error_cnt = 0;
	int          n_compared = 0;
	int          n;
	always #5 pclk = ~pclk;
	sprc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .power_ok, .ext_reset_n, .ext_reset_enable, .watchdog_expire, .watchdog_enable,
		.brownout_low, .brownout_enable, .tout_cycles, .ext_crystal_sel(1'b1), .sleep_instr,
		.wake_event, .wake_pin_mask, .internal_reset, .io_port_reset, .cpu_clock_run,
		.flash_clock_run, .io_clock_run, .converter_clock_run, .osc_run, .brownout_detector_off,
		.input_buffer_en, .timer1_clock_en, .timer0_clock_en, .serial_iface_clock_en,
		.converter_clock_en, .comparator_mux_allow, .timer1_access_en, .timer0_access_en,
		.serial_iface_access_en, .converter_access_en, .sleeping);
	task print_verdict;
		$display("mismatches %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task timeout_hit;
		error_cnt++;
		$display("ERROR %0t wait ran out", $time);
		print_verdict();
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task apb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) timeout_hit();
	endtask
	// polled on the falling edge so combinational outputs have settled
	task wait_rst;
		n = 0;
		while (internal_reset !== 1'b0 && n < 100) begin
			@(negedge pclk);
			n++;
		end
		if (n == 100) timeout_hit();
	endtask
	task slp;
		@(posedge pclk);
		sleep_instr <= 1'b1;
		@(posedge pclk);
		sleep_instr <= 1'b0;
		repeat (2) @(negedge pclk);
	endtask
	task wake;
		int i;
		@(posedge pclk);
		wake_event <= 1'b1;
		@(posedge pclk);
		wake_event <= 1'b0;
		for (i = 0; i < 20 && sleeping !== 1'b0; i++) @(negedge pclk);
		if (i == 20) timeout_hit();
	endtask
	// unlock write, gap, set write, lag, then power-down sleep
	task brownout_sleep_off_try(input int gap, input int lag, input logic exp);
		apb(1'b1, sprc_pkg::ADDR_CTRL, 32'hB4);
		repeat (gap) @(posedge pclk);
		apb(1'b1, sprc_pkg::ADDR_CTRL, 32'hB0);
		repeat (lag) @(posedge pclk);
		slp();
		chk(32'(brownout_detector_off), 32'(exp), "brown-out off in sleep");
		wake();
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		wait_rst();
		apb(1'b0, sprc_pkg::ADDR_CTRL, 32'h0);
		chk(q, 32'h0, "ctrl reset");
		apb(1'b0, sprc_pkg::ADDR_PRR, 32'h0);
		chk(q, 32'h0, "prr reset");
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, sprc_pkg::ADDR_PRR, 32'hF0 | (32'h1 << i));
			apb(1'b0, sprc_pkg::ADDR_PRR, 32'h0);
			chk(q, 32'h1 << i, "prr readback");
			chk(32'({timer1_clock_en, timer0_clock_en, serial_iface_clock_en, converter_clock_en}),
				~(32'h1 << i) & 32'hF, "clock gates");
			chk(32'({timer1_access_en, timer0_access_en, serial_iface_access_en,
				converter_access_en}), ~(32'h1 << i) & 32'hF, "access gates");
			chk(32'(comparator_mux_allow), 32'(i != 0), "comparator mux");
		end
		apb(1'b1, sprc_pkg::ADDR_PRR, 32'h0);
		apb(1'b1, 4'h2, 32'hFF);
		chk(32'(e), 32'h1, "unmapped write");
		apb(1'b0, 4'h2, 32'h0);
		chk(32'(e), 32'h1, "unmapped read");
		$display("test power reduction done");
		brownout_sleep_off_try(0, 2, 1'b1);
		brownout_sleep_off_try(3, 2, 1'b0);
		brownout_sleep_off_try(0, 8, 1'b0);
		$display("test brown-out sleep done");
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, sprc_pkg::ADDR_CTRL, 32'h20 | 32'(m << 3));
			slp();
			chk(32'({sleeping, io_clock_run, converter_clock_run, osc_run}), 32'(mode_exp[m]),
				"mode clocks");
			chk(32'({cpu_clock_run, flash_clock_run}), 32'h0, "core clocks stopped");
			apb(1'b0, sprc_pkg::ADDR_STATUS, 32'h0);
			chk(q, 32'(m), "status mode");
			wake();
		end
		apb(1'b1, sprc_pkg::ADDR_CTRL, 32'h10);
		slp();
		chk(32'(sleeping), 32'h0, "sleep without enable");
		apb(1'b1, sprc_pkg::ADDR_CTRL, 32'h20);
		apb(1'b1, sprc_pkg::ADDR_SLPCMD, 32'h0);
		@(negedge pclk);
		chk(32'(sleeping), 32'h1, "command sleep");
		wake();
		$display("test sleep modes done");
		@(posedge pclk);
		{ext_reset_enable, brownout_enable, watchdog_enable} <= 3'b000;
		{ext_reset_n, brownout_low, watchdog_expire} <= 3'b011;
		repeat (3) @(negedge pclk);
		chk(32'(internal_reset), 32'h0, "masked sources");
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, sprc_pkg::ADDR_CTRL, 32'h28);
			@(posedge pclk);
			{ext_reset_enable, brownout_enable, watchdog_enable} <= 3'b111;
			{power_ok, ext_reset_n} <= {k != 0, k != 1};
			{watchdog_expire, brownout_low} <= {k == 2, k == 3};
			repeat (2) @(negedge pclk);
			chk(32'({internal_reset, io_port_reset}), 32'h3, "source reset");
			@(posedge pclk);
			{power_ok, ext_reset_n, watchdog_expire, brownout_low} <= 4'b1100;
			wait_rst();
			chk(32'(n >= 3 && n <= 7), 32'h1, "stretch length");
			apb(1'b0, sprc_pkg::ADDR_CTRL, 32'h0);
			chk(q, 32'h0, "ctrl after reset");
		end
		$display("test reset sources done");
		print_verdict();
	end
endmodule // sleep_power_reset_control_tb_top
